// >>> src/mq_pkg.sv
// shared constants, register map and types for the multi-queue flag block
package mq_pkg;
  // ==========================================================
  // geometry
  localparam int NQ    = 4;
  localparam int QA_W  = 2;
  localparam int D_W   = 16;
  localparam int CNT_W = 18;
  localparam int AXI_AW = 8;
  localparam int CFG_W = 4;
  // ==========================================================
  // register map
  localparam logic [AXI_AW-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_DEPTH  = 8'h10;
  localparam logic [AXI_AW-1:0] ADDR_AF_OFF = 8'h20;
  localparam logic [AXI_AW-1:0] ADDR_AE_OFF = 8'h30;
  localparam logic [AXI_AW-1:0] QSTEP       = 8'h04;
  localparam int CFG_IN9  = 0;
  localparam int CFG_OUT9 = 1;
  localparam int CFG_DF   = 2;
  localparam int CFG_PROG = 3;
  localparam logic [CFG_W-1:0] CONFIG_RESET = 4'h0;
  localparam logic [D_W-1:0]   DEPTH_RESET  = 16'h0100;
  localparam logic [D_W-1:0]   OFF_RESET    = 16'h0008;
  localparam logic [D_W-1:0]   OFF_DF_LO    = 16'h0008;
  localparam logic [D_W-1:0]   OFF_DF_HI    = 16'h0080;
  localparam logic [1:0]       RESP_OKAY    = 2'h0;
  localparam logic [1:0]       RESP_SLVERR  = 2'h2;
  // ==========================================================
  // flag vector layout and occupancy units
  localparam int F_FULL  = 0;
  localparam int F_AF    = 1;
  localparam int F_AE    = 2;
  localparam int F_EMPTY = 3;
  localparam logic [1:0] UNIT_BYTE = 2'h1;
  localparam logic [1:0] UNIT_WORD = 2'h2;
  localparam logic [1:0] AGE_MAX   = 2'h3;
  typedef enum {SEL_STEADY, SEL_SWITCH} sel_state_t;
endpackage

// >>> src/cfg_if.sv
// configuration and status bundle between register slave and flag core
interface cfg_if;
  import mq_pkg::*;
  logic                    in9;
  logic                    out9;
  logic [NQ-1:0][D_W-1:0]  depth;
  logic [NQ-1:0][D_W-1:0]  af_off;
  logic [NQ-1:0][D_W-1:0]  ae_off;
  logic [4*NQ-1:0]         status;
  modport regs (output in9, output out9, output depth, output af_off, output ae_off, input status);
  modport core (input in9, input out9, input depth, input af_off, input ae_off, output status);
endinterface

// >>> src/queue_counters.sv
// per-queue write and read totals with the one-cycle cross-port skew stage
module queue_counters
  import mq_pkg::*;
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        wr_go,
  input  wire logic [QA_W-1:0]             wr_q,
  input  wire logic [1:0]                  wr_units,
  input  wire logic                        rd_go,
  input  wire logic [QA_W-1:0]             rd_q,
  input  wire logic [1:0]                  rd_units,
  output wire logic [NQ-1:0][CNT_W-1:0]    fill_w,
  output wire logic [NQ-1:0][CNT_W-1:0]    fill_r,
  output wire logic [NQ-1:0][CNT_W-1:0]    fill_w_next,
  output wire logic [NQ-1:0][CNT_W-1:0]    fill_r_next
);
  // ==========================================================
  // one counter set per queue
  for (genvar q = 0; q < NQ; q++) begin : g_q
    logic [CNT_W-1:0] wr_total, rd_total, wr_sync, rd_sync, next_wr, next_rd;
    // totals advance by the port width in byte units
    assign next_wr = (wr_go && wr_q == QA_W'(q)) ? wr_total + CNT_W'(wr_units) : wr_total;
    assign next_rd = (rd_go && rd_q == QA_W'(q)) ? rd_total + CNT_W'(rd_units) : rd_total;
    // each port sees the other port's total one stage late
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wr_total <= '0;
        rd_total <= '0;
        wr_sync  <= '0;
        rd_sync  <= '0;
      end else begin
        wr_total <= next_wr;
        rd_total <= next_rd;
        wr_sync  <= wr_total;
        rd_sync  <= rd_total;
      end
    end
    // occupancy as seen from each port
    assign fill_w[q]      = wr_total - rd_sync;
    assign fill_w_next[q] = next_wr - rd_sync;
    assign fill_r[q]      = wr_sync - rd_total;
    assign fill_r_next[q] = wr_sync - next_rd;
  end
endmodule

// >>> src/axi_regs.sv
// axi4-lite register slave for queue geometry, offsets and status
module axi_regs
  import mq_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output wire logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output wire logic              arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  cfg_if.regs                    cfg
);
  logic                   aw_got, w_got;
  logic [AXI_AW-1:0]      aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic [CFG_W-1:0]       config_reg;
  logic [NQ-1:0][D_W-1:0] depth, af_reg, ae_reg;
  wire                    do_wr = aw_got && w_got;

  // decode of every implemented address
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a == ADDR_CONFIG) || (a == ADDR_STATUS);
    for (int q = 0; q < NQ; q++) begin
      mapped = mapped || (a == ADDR_DEPTH + 8'(q) * QSTEP) || (a == ADDR_AF_OFF + 8'(q) * QSTEP)
               || (a == ADDR_AE_OFF + 8'(q) * QSTEP);
    end
  endfunction
  // byte-lane merge of a 16-bit field
  function automatic logic [D_W-1:0] merge(input logic [D_W-1:0] old, input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ==========================================================
  // write channels, taken in either order
  assign awready = !aw_got && !bvalid;
  assign wready  = !w_got && !bvalid;
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else if (do_wr) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end
  // write response, error on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // configuration and per-queue registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= CONFIG_RESET;
      for (int q = 0; q < NQ; q++) begin
        depth[q]  <= DEPTH_RESET;
        af_reg[q] <= OFF_RESET;
        ae_reg[q] <= OFF_RESET;
      end
    end else if (do_wr) begin
      if (aw_addr == ADDR_CONFIG && w_strb[0]) begin
        config_reg <= w_data[CFG_W-1:0];
      end
      for (int q = 0; q < NQ; q++) begin
        if (aw_addr == ADDR_DEPTH + 8'(q) * QSTEP) depth[q] <= merge(depth[q], w_data, w_strb);
        if (aw_addr == ADDR_AF_OFF + 8'(q) * QSTEP) af_reg[q] <= merge(af_reg[q], w_data, w_strb);
        if (aw_addr == ADDR_AE_OFF + 8'(q) * QSTEP) ae_reg[q] <= merge(ae_reg[q], w_data, w_strb);
      end
    end
  end
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata  <= '0;
      if (araddr == ADDR_CONFIG) rdata <= 32'(config_reg);
      if (araddr == ADDR_STATUS) rdata <= 32'(cfg.status);
      for (int q = 0; q < NQ; q++) begin
        if (araddr == ADDR_DEPTH + 8'(q) * QSTEP) rdata <= 32'(depth[q]);
        if (araddr == ADDR_AF_OFF + 8'(q) * QSTEP) rdata <= 32'(af_reg[q]);
        if (araddr == ADDR_AE_OFF + 8'(q) * QSTEP) rdata <= 32'(ae_reg[q]);
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // effective offsets: programmed or one of two defaults
  always_comb begin
    cfg.in9   = config_reg[CFG_IN9];
    cfg.out9  = config_reg[CFG_OUT9];
    cfg.depth = depth;
    for (int q = 0; q < NQ; q++) begin
      cfg.af_off[q] = config_reg[CFG_PROG] ? af_reg[q] : (config_reg[CFG_DF] ? OFF_DF_HI : OFF_DF_LO);
      cfg.ae_off[q] = config_reg[CFG_PROG] ? ae_reg[q] : (config_reg[CFG_DF] ? OFF_DF_HI : OFF_DF_LO);
    end
  end
endmodule

// >>> src/multi_queue_flags.sv
// active-queue full, almost-full, almost-empty and output-valid flags of a four-queue buffer
// ==========================================================
// Function
// - almost-full kept per queue, output shows only the write-selected queue
// - each queue has its own almost-full offset, programmed or default 8/128
// - write select taken on strobe edge, flags show new queue two edges later
// - almost-full goes low two cycles after the write reaching the boundary
// - read releases almost-full one cycle after the skew stage
// - almost-full output changes on clock edges only; stored status follows reads
// - almost-empty kept per queue, output shows only the read-selected queue
// - each queue has its own almost-empty offset, programmed or default 8/128
// - read select taken on strobe edge, flags show new queue two edges later
// - almost-empty goes low two cycles after the read reaching the boundary
// - write releases almost-empty one cycle after the skew stage
// - almost-empty output changes on clock edges only; stored status follows writes
// - output-valid low after first write, or second write for 9-in 18-out
// - output-valid low one cycle after write plus skew, high on read edge
// - full after D+1 writes with both ports selected, D otherwise, 18-to-9 always D
// - 9-in 18-out with both ports selected: full after 2(D+1) writes
// - 9-in 18-out with only write port selected: full after 2D writes
// - full low on the filling write edge, released after read plus skew
// - flags active low; almost-full at D+1-m writes, almost-empty clears at n+2
module multi_queue_flags
  import mq_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output wire logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output wire logic              bvalid,
  input  wire logic              bready,
  output wire logic [1:0]        bresp,
  input  wire logic              arvalid,
  output wire logic              arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output wire logic              rvalid,
  input  wire logic              rready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  input  wire logic [QA_W-1:0]   write_queue_addr,
  input  wire logic              write_addr_strobe,
  input  wire logic              write_req,
  input  wire logic [QA_W-1:0]   read_queue_addr,
  input  wire logic              read_addr_strobe,
  input  wire logic              read_req,
  output logic                   full_n,
  output logic                   almost_full_n,
  output logic                   output_valid_n,
  output logic                   almost_empty_n
);
  // ==========================================================
  // register slave
  cfg_if cfg ();

  axi_regs regs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .cfg     (cfg.regs)
  );

  // ==========================================================
  // queue selection on both ports
  logic [QA_W-1:0] wsel, rsel;
  sel_state_t      wstate, rstate;
  logic [1:0]      w_age, r_age;

  // write-port selection, one hold cycle after each strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wsel   <= '0;
      wstate <= SEL_STEADY;
    end else begin
      if (write_addr_strobe) wsel <= write_queue_addr;
      case (wstate)
        SEL_STEADY: wstate <= write_addr_strobe ? SEL_SWITCH : SEL_STEADY;
        SEL_SWITCH: wstate <= write_addr_strobe ? SEL_SWITCH : SEL_STEADY;
        default:    wstate <= SEL_STEADY;
      endcase
    end
  end
  // read-port selection, one hold cycle after each strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsel   <= '0;
      rstate <= SEL_STEADY;
    end else begin
      if (read_addr_strobe) rsel <= read_queue_addr;
      case (rstate)
        SEL_STEADY: rstate <= read_addr_strobe ? SEL_SWITCH : SEL_STEADY;
        SEL_SWITCH: rstate <= read_addr_strobe ? SEL_SWITCH : SEL_STEADY;
        default:    rstate <= SEL_STEADY;
      endcase
    end
  end
  // cycles since the last strobe, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_age <= '0;
      r_age <= '0;
    end else begin
      w_age <= write_addr_strobe ? 2'h0 : ((w_age == AGE_MAX) ? AGE_MAX : w_age + 2'h1);
      r_age <= read_addr_strobe ? 2'h0 : ((r_age == AGE_MAX) ? AGE_MAX : r_age + 2'h1);
    end
  end

  // ==========================================================
  // bus matching: occupancy is counted in 9-bit units
  wire                 split = !cfg.in9 && cfg.out9;   // 18 in, 9 out
  wire                 wide  = !(cfg.in9 && cfg.out9); // one depth entry is two units
  wire [1:0]           win_u  = cfg.in9 ? UNIT_BYTE : UNIT_WORD;
  wire [1:0]           wout_u = cfg.out9 ? UNIT_BYTE : UNIT_WORD;
  wire [CNT_W-1:0]     need   = {{(CNT_W-2){1'b0}}, wout_u};
  wire [CNT_W-1:0]     unit   = {{(CNT_W-2){1'b0}}, wide ? UNIT_WORD : UNIT_BYTE};

  // depth or offset scaled to units
  function automatic logic [CNT_W-1:0] scale(input logic [D_W-1:0] v, input logic two);
    scale = two ? {1'b0, v, 1'b0} : {2'b00, v};
  endfunction
  // flag vector from an occupancy and the queue thresholds
  function automatic logic [3:0] flags_of(input logic [CNT_W-1:0] fill, input logic [CNT_W-1:0] cap,
                                          input logic [CNT_W-1:0] afthr, input logic [CNT_W-1:0] aethr,
                                          input logic [CNT_W-1:0] nd);
    flags_of = {fill < nd, fill < aethr, fill >= afthr, fill >= cap};
  endfunction

  // ==========================================================
  // occupancy counters
  wire [NQ-1:0][CNT_W-1:0] fill_w, fill_r, fill_w_next, fill_r_next;
  wire [NQ-1:0][3:0]       wflags, rflags, wflags_next, rflags_next;
  logic [NQ-1:0]           primed;
  logic                    af_pipe, ae_pipe;
  // writes refused while full or switching, reads while no valid word or switching
  wire                     wr_go = write_req && full_n && wstate == SEL_STEADY;
  wire                     rd_go = read_req && !output_valid_n && rstate == SEL_STEADY;

  queue_counters counters (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .wr_go       (wr_go),
    .wr_q        (wsel),
    .wr_units    (win_u),
    .rd_go       (rd_go),
    .rd_q        (rsel),
    .rd_units    (wout_u),
    .fill_w      (fill_w),
    .fill_r      (fill_r),
    .fill_w_next (fill_w_next),
    .fill_r_next (fill_r_next)
  );

  // per-queue thresholds and stored status of every queue
  for (genvar q = 0; q < NQ; q++) begin : g_thr
    wire [CNT_W-1:0] m_u = scale(cfg.af_off[q], wide);
    // output register holds one word once the read port owns the queue, except 18-to-9
    wire [CNT_W-1:0] cap = scale(cfg.depth[q], wide) + ((primed[q] && !split) ? need : '0);
    // almost-full at cap minus offset, i.e. D+1-m writes
    wire [CNT_W-1:0] afthr = (m_u >= cap) ? '0 : cap - m_u;
    // almost-empty clears at n+2 writes (n+1 for 18-to-9)
    wire [CNT_W-1:0] aethr = scale(cfg.ae_off[q], wide) + need + (split ? '0 : unit);
    // output-valid once a whole output word is present
    assign wflags[q]      = flags_of(fill_w[q], cap, afthr, aethr, need);
    assign wflags_next[q] = flags_of(fill_w_next[q], cap, afthr, aethr, need);
    assign rflags[q]      = flags_of(fill_r[q], cap, afthr, aethr, need);
    assign rflags_next[q] = flags_of(fill_r_next[q], cap, afthr, aethr, need);
  end

  // fall-through credit: set while read port owns the queue, dropped when it drains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primed <= '0;
    end else begin
      for (int q = 0; q < NQ; q++) begin
        if (rsel == QA_W'(q) && rstate == SEL_STEADY) primed[q] <= 1'b1;
        else if (fill_r[q] == '0) primed[q] <= 1'b0;
      end
    end
  end

  // status word for software
  always_comb begin
    cfg.status = '0;
    for (int q = 0; q < NQ; q++) begin
      cfg.status[q]        = wflags[q][F_FULL];
      cfg.status[NQ+q]     = wflags[q][F_AF];
      cfg.status[2*NQ+q]   = rflags[q][F_AE];
      cfg.status[3*NQ+q]   = rflags[q][F_EMPTY];
    end
  end

  // ==========================================================
  // active-queue outputs
  wire [3:0] w_cur = wflags[wsel];
  wire [3:0] w_nxt = wflags_next[wsel];
  wire [3:0] r_cur = rflags[rsel];
  wire [3:0] r_nxt = rflags_next[rsel];
  wire       af_now = w_cur[F_AF];
  wire       ae_now = r_cur[F_AE];

  // full on the filling write edge, held during a switch
  always_ff @(posedge aclk) begin
    if (!aresetn) full_n <= 1'b1;
    else if (wstate == SEL_STEADY) full_n <= !w_nxt[F_FULL];
  end
  // almost-full double registered; release needs only the current stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      af_pipe       <= 1'b0;
      almost_full_n <= 1'b1;
    end else begin
      af_pipe <= af_now;
      if (wstate == SEL_STEADY) almost_full_n <= !(af_pipe && af_now);
    end
  end
  // output-valid: low after write plus skew, high on the read edge
  always_ff @(posedge aclk) begin
    if (!aresetn) output_valid_n <= 1'b1;
    else if (rstate == SEL_STEADY) output_valid_n <= r_nxt[F_EMPTY];
  end
  // almost-empty double registered; release needs only the current stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ae_pipe        <= 1'b1;
      almost_empty_n <= 1'b0;
    end else begin
      ae_pipe <= ae_now;
      if (rstate == SEL_STEADY) almost_empty_n <= !(ae_pipe && ae_now);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_af_out_lag: assert property ((w_age == AGE_MAX) |->
    (almost_full_n == !($past(af_now) && $past(af_now, 2))))
    else $error("almost-full output lag wrong");
  a_ae_out_lag: assert property ((r_age == AGE_MAX) |->
    (almost_empty_n == !($past(ae_now) && $past(ae_now, 2))))
    else $error("almost-empty output lag wrong");
  a_full_on_edge: assert property ((w_age > 2'h1) |->
    (full_n == !$past(w_nxt[F_FULL])))
    else $error("full flag not set on filling edge");
  a_ov_on_edge: assert property ((r_age > 2'h1) |->
    (output_valid_n == $past(r_nxt[F_EMPTY])))
    else $error("output-valid timing wrong");
  a_wsel_load: assert property (write_addr_strobe |=> (wsel == $past(write_queue_addr)))
    else $error("write queue not loaded");
  a_rsel_hold: assert property (!read_addr_strobe |=> $stable(rsel))
    else $error("read queue changed without strobe");
  a_wswitch_hold: assert property (write_addr_strobe |=> ##1 ($stable(almost_full_n) && $stable(full_n)))
    else $error("write flags moved during switch");
  a_rswitch_hold: assert property (read_addr_strobe |=> ##1 ($stable(almost_empty_n) && $stable(output_valid_n)))
    else $error("read flags moved during switch");
  a_no_overfill: assert property (wr_go |-> !w_cur[F_FULL])
    else $error("write accepted into full queue");
  a_read_valid: assert property (rd_go |-> !r_cur[F_EMPTY])
    else $error("read accepted from empty queue");
  a_af_before_full: assert property (w_cur[F_FULL] |-> w_cur[F_AF])
    else $error("full without almost-full");
  a_ae_when_empty: assert property (r_cur[F_EMPTY] |-> r_cur[F_AE])
    else $error("empty without almost-empty");

  c_af_low: cover property ($fell(almost_full_n));
  c_full_low: cover property ($fell(full_n) ##[1:40] $rose(full_n));
  c_ae_high: cover property ($rose(almost_empty_n));
  c_ov_switch: cover property (read_addr_strobe ##3 $changed(output_valid_n));
endmodule

// >>> tb/ctrl_model.sv
// system controller model driving queue selects and transfer requests
module ctrl_model
  import mq_pkg::*;
(
  input  wire logic       aclk,
  output logic [QA_W-1:0] write_queue_addr,
  output logic            write_addr_strobe,
  output logic            write_req,
  output logic [QA_W-1:0] read_queue_addr,
  output logic            read_addr_strobe,
  output logic            read_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {write_queue_addr, write_addr_strobe, write_req} = '0;
    {read_queue_addr, read_addr_strobe, read_req} = '0;
  end
  // one strobe edge with the queue number, then a quiet switch cycle
  task automatic sel(input bit rd, input logic [QA_W-1:0] q);
    @(posedge aclk);
    read_queue_addr <= rd ? q : read_queue_addr;
    read_addr_strobe <= rd;
    write_queue_addr <= rd ? write_queue_addr : q;
    write_addr_strobe <= !rd;
    @(posedge aclk);
    read_addr_strobe <= 1'h0;
    write_addr_strobe <= 1'h0;
  endtask
  // hold a request for k edges, one word per edge
  task automatic xfer(input bit rd, input int k);
    @(posedge aclk);
    read_req <= rd;
    write_req <= !rd;
    repeat (k) @(posedge aclk);
    read_req <= 1'h0;
    write_req <= 1'h0;
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the multi-queue flag block
module tb_top
  import mq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [QA_W-1:0] write_queue_addr, read_queue_addr;
  logic write_addr_strobe, write_req, read_addr_strobe, read_req;
  logic full_n, almost_full_n, output_valid_n, almost_empty_n;
  int n_mismatch, samples_checked;
  multi_queue_flags dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .write_queue_addr, .write_addr_strobe, .write_req, .read_queue_addr, .read_addr_strobe, .read_req,
    .full_n, .almost_full_n, .output_valid_n, .almost_empty_n);
  ctrl_model ctrl (.aclk, .write_queue_addr, .write_addr_strobe, .write_req, .read_queue_addr,
    .read_addr_strobe, .read_req);
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  task automatic report_and_stop;
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  // axi access: hold each channel until its handshake edge, bounded wait
  task automatic axi(input bit wr, input logic [AXI_AW-1:0] a, input logic [31:0] d);
    bit ha, hw, hr;
    int i;
    @(posedge aclk);
    {awaddr, araddr, wdata, wstrb} <= {a, a, d, 4'h3};
    {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
    hr = 0;
    for (i = 0; !hr; i++) begin
      if (i == 64) begin
        n_mismatch++;
        report_and_stop;
      end
      #1;
      ha = (awvalid && awready) || (arvalid && arready);
      hw = wvalid && wready;
      hr = (bready && bvalid) || (rready && rvalid);
      {got, resp} = wr ? {32'h0000_0000, bresp} : {rdata, rresp};
      @(posedge aclk);
      if (ha) {awvalid, arvalid} <= 2'h0;
      if (hw) wvalid <= 1'h0;
    end
    {bready, rready} <= 2'h0;
  endtask
  task automatic check_regs;
    axi(0, ADDR_CONFIG, 0);
    chk(got, 32'h0000_0000);
    axi(0, ADDR_AF_OFF + QSTEP, 0);
    chk(got, 32'h0000_0008);
    axi(0, ADDR_AE_OFF, 0);
    chk(got, 32'h0000_0008);
    axi(0, 8'h08, 0);
    chk(resp, RESP_SLVERR);
    axi(1, ADDR_DEPTH + 8'h08, 32'h0000_0040);
    chk(resp, RESP_OKAY);
    axi(0, ADDR_DEPTH + 8'h08, 0);
    chk(got, 32'h0000_0040);
    $display("register test done");
  endtask
  // 9-bit in, 18-bit out on queue 3 with both ports selected
  task automatic bus_match;
    axi(1, ADDR_CONFIG, 32'h0000_0001);
    chk(resp, RESP_OKAY);
    axi(1, ADDR_DEPTH + 8'h0C, 32'h0000_0004);
    chk(resp, RESP_OKAY);
    ctrl.sel(0, 2'h3);
    ctrl.sel(1, 2'h3);
    ctrl.xfer(0, 1);
    settle(2);
    chk(output_valid_n, 1'h1);
    ctrl.xfer(0, 1);
    settle(2);
    chk(output_valid_n, 1'h0);
    ctrl.xfer(0, 7);
    settle(0);
    chk(full_n, 1'h1);
    ctrl.xfer(0, 1);
    settle(0);
    chk(full_n, 1'h0);
    $display("bus matching test done");
  endtask
  // fill queue 0 with both ports on it, then free one word
  task automatic fill_queue;
    settle(0);
    chk({full_n, almost_full_n, output_valid_n, almost_empty_n}, 4'hE);
    ctrl.xfer(0, 1);
    settle(1);
    chk(output_valid_n, 1'h1);
    settle(1);
    chk(output_valid_n, 1'h0);
    ctrl.xfer(0, 8);
    settle(2);
    chk(almost_empty_n, 1'h0);
    ctrl.xfer(0, 1);
    settle(2);
    chk(almost_empty_n, 1'h1);
    ctrl.xfer(0, 239);
    settle(1);
    chk(almost_full_n, 1'h1);
    settle(1);
    chk(almost_full_n, 1'h0);
    ctrl.xfer(0, 8);
    settle(0);
    chk(full_n, 1'h0);
    ctrl.xfer(1, 1);
    settle(1);
    chk(full_n, 1'h0);
    settle(1);
    chk(full_n, 1'h1);
    $display("fill test done");
  endtask
  task automatic switch_queues;
    ctrl.sel(0, 1);
    settle(1);
    chk(almost_full_n, 1'h0);
    settle(1);
    chk(almost_full_n, 1'h1);
    ctrl.xfer(0, 1);
    ctrl.sel(1, 1);
    settle(1);
    chk(almost_empty_n, 1'h1);
    settle(1);
    chk({output_valid_n, almost_empty_n}, 2'h0);
    ctrl.xfer(1, 1);
    settle(0);
    chk(output_valid_n, 1'h1);
    ctrl.sel(1, 0);
    settle(2);
    chk({output_valid_n, almost_empty_n}, 2'h1);
    $display("switch test done");
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    fill_queue();
    switch_queues();
    check_regs();
    bus_match();
    report_and_stop();
  end
endmodule
